// ---- boe_defines.vh ----
// Opcode patterns, field positions, reset values and stack depth for the byte operation execute unit.
`ifndef BOE_DEFINES_VH
`define BOE_DEFINES_VH
`define BOE_OP6_ADD_REG    6'h07
`define BOE_OP6_AND_REG    6'h05
`define BOE_OP6_DEC_SKIP   6'h0b
`define BOE_OP6_INC        6'h0a
`define BOE_OP6_INC_SKIP   6'h0f
`define BOE_OP6_OR_REG     6'h04
`define BOE_OP6_ROT_LEFT   6'h0d
`define BOE_OP5_ADD_LIT    5'h1f
`define BOE_OP6_AND_LIT    6'h39
`define BOE_OP6_OR_LIT     6'h38
`define BOE_OP4_LOAD_LIT   4'hc
`define BOE_OP4_RET_LIT    4'hd
`define BOE_OP3_JUMP       3'h5
`define BOE_INSN_RET_IRQ   14'h0009
`define BOE_INSN_RET_CALL  14'h0008
`define BOE_DEST_BIT       7
`define BOE_LATCH_HI       4
`define BOE_LATCH_LO       3
`define BOE_GIE_BIT        7
`define BOE_FLAG_C         0
`define BOE_FLAG_DC        1
`define BOE_FLAG_Z         2
`define BOE_PC_RESET       13'h0000
`define BOE_ACC_RESET      8'h00
`define BOE_STACK_DEPTH    8
`endif

// ---- boe_alu.v ----
// Combinational result and flag unit for register and literal operations.
`timescale 1ns/1ps
module boe_alu (
  // Operands
  input  wire [13:0] insn,
  input  wire [7:0]  acc,
  input  wire [7:0]  reg_val,
  input  wire        carry_in,
  // Results
  output reg  [7:0]  result,
  output reg         carry_out,
  output reg         nib_out,
  output reg         upd_c,
  output reg         upd_dc,
  output reg         upd_z,
  output reg         skip
);
`include "boe_defines.vh"
  reg [8:0] sum;
  reg [4:0] nsum;
  always @* begin
    result    = 8'h00;
    carry_out = carry_in;
    nib_out   = 1'b0;
    upd_c     = 1'b0;
    upd_dc    = 1'b0;
    upd_z     = 1'b0;
    skip      = 1'b0;
    sum       = 9'h000;
    nsum      = 5'h00;
    if (insn[13:9] == `BOE_OP5_ADD_LIT) begin
      sum       = {1'b0, acc} + {1'b0, insn[7:0]};
      nsum      = {1'b0, acc[3:0]} + {1'b0, insn[3:0]};
      result    = sum[7:0];
      carry_out = sum[8];
      nib_out   = nsum[4];
      upd_c     = 1'b1;
      upd_dc    = 1'b1;
      upd_z     = 1'b1;
    end else if (insn[13:8] == `BOE_OP6_AND_LIT) begin
      result = acc & insn[7:0];
      upd_z  = 1'b1;
    end else if (insn[13:8] == `BOE_OP6_OR_LIT) begin
      result = acc | insn[7:0];
      upd_z  = 1'b1;
    end else begin
      case (insn[13:8])
        `BOE_OP6_ADD_REG: begin
          sum       = {1'b0, acc} + {1'b0, reg_val};
          nsum      = {1'b0, acc[3:0]} + {1'b0, reg_val[3:0]};
          result    = sum[7:0];
          carry_out = sum[8];
          nib_out   = nsum[4];
          upd_c     = 1'b1;
          upd_dc    = 1'b1;
          upd_z     = 1'b1;
        end
        `BOE_OP6_AND_REG: begin
          result = acc & reg_val;
          upd_z  = 1'b1;
        end
        `BOE_OP6_OR_REG: begin
          result = acc | reg_val;
          upd_z  = 1'b1;
        end
        `BOE_OP6_INC: begin
          result = reg_val + 8'h01;
          upd_z  = 1'b1;
        end
        `BOE_OP6_DEC_SKIP: begin
          result = reg_val - 8'h01;
          skip   = (result == 8'h00);
        end
        `BOE_OP6_INC_SKIP: begin
          result = reg_val + 8'h01;
          skip   = (result == 8'h00);
        end
        `BOE_OP6_ROT_LEFT: begin
          result    = {reg_val[6:0], carry_in};
          carry_out = reg_val[7];
          upd_c     = 1'b1;
        end
        default: begin
          result = 8'h00;
        end
      endcase
    end
  end
endmodule

// ---- boe_exec_unit.v ----
// Decode and execute core: fetch, accumulator, flags, register file, stack and program counter.
`timescale 1ns/1ps
// How it works
// - Add literal to accumulator, all three flags.
// - Add accumulator and register, all three flags.
// - Destination bit selects accumulator or register.
// - AND literal into accumulator, zero flag only.
// - AND accumulator with register, zero flag.
// - Decrement, skip next when zero, no flags.
// - Increment register, zero flag only.
// - Increment, skip next when zero, no flags.
// - Jump loads eleven bits, two cycles.
// - Jump upper bits come from upper latch.
// - OR accumulator with register, zero flag.
// - OR literal into accumulator, zero flag.
// - Load literal, no flags, ignore spare bits.
// - Return from irq pops, sets global enable.
// - Return with literal loads accumulator, pops.
// - Return pops stack into program counter.
// - Rotate left through carry, carry only.
module boe_exec_unit (
  // Clock and reset
  input  wire        clock,
  input  wire        resetn,
  // Program memory
  output reg  [12:0] pm_addr_q,
  input  wire [13:0] pm_data,
  // Software-visible control written by other core logic
  input  wire        latch_we,
  input  wire [7:0]  latch_wdata,
  input  wire        stack_push,
  input  wire [12:0] stack_push_addr,
  // State
  output reg  [7:0]  acc_q,
  output reg  [2:0]  status_q,
  output reg  [12:0] pc_q,
  output reg         gie_q,
  output reg  [7:0]  upper_latch_q,
  output reg         flush_q,
  // APB register port
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);
`include "boe_defines.vh"
  // Register file, one byte per address.
  reg  [7:0]  regs_q [0:127];
  reg  [12:0] stack_q [0:`BOE_STACK_DEPTH-1];
  reg  [2:0]  sp_q;
  reg  [13:0] insn_q;
  reg         valid_q;
  reg  [12:0] pc_d;
  wire [7:0]  reg_val;
  wire [7:0]  result;
  wire        carry_out;
  wire        nib_out;
  wire        upd_c;
  wire        upd_dc;
  wire        upd_z;
  wire        skip;
  wire        is_reg_op;
  wire        is_jump;
  wire        is_ret;
  wire        is_ret_irq;
  wire        is_ret_lit;
  wire        is_load_lit;
  wire        do_exec;
  wire        apb_go;
  wire        is_lit_op;
  wire [2:0]  sp_pop;

  function is_reg_opcode;
    input [5:0] op;
    begin
      is_reg_opcode = (op == `BOE_OP6_ADD_REG) || (op == `BOE_OP6_AND_REG) ||
                      (op == `BOE_OP6_DEC_SKIP) || (op == `BOE_OP6_INC) ||
                      (op == `BOE_OP6_INC_SKIP) || (op == `BOE_OP6_OR_REG) ||
                      (op == `BOE_OP6_ROT_LEFT);
    end
  endfunction

  // Only the literal operations the unit implements may load the accumulator from the ALU.
  function is_lit_opcode;
    input [13:0] word;
    begin
      is_lit_opcode = (word[13:9] == `BOE_OP5_ADD_LIT) || (word[13:8] == `BOE_OP6_AND_LIT) ||
                      (word[13:8] == `BOE_OP6_OR_LIT);
    end
  endfunction

  assign do_exec     = valid_q & ~flush_q;
  assign reg_val     = regs_q[insn_q[6:0]];
  assign is_reg_op   = is_reg_opcode(insn_q[13:8]);
  assign is_jump     = (insn_q[13:11] == `BOE_OP3_JUMP);
  assign is_ret_irq  = (insn_q == `BOE_INSN_RET_IRQ);
  assign is_ret      = (insn_q == `BOE_INSN_RET_CALL) || is_ret_irq;
  assign is_ret_lit  = (insn_q[13:10] == `BOE_OP4_RET_LIT);
  assign is_load_lit = (insn_q[13:10] == `BOE_OP4_LOAD_LIT);
  assign is_lit_op   = is_lit_opcode(insn_q);
  assign sp_pop      = sp_q - 3'h1;
  assign apb_go      = psel & penable;

  boe_alu u_alu (
    .insn      (insn_q),
    .acc       (acc_q),
    .reg_val   (reg_val),
    .carry_in  (status_q[`BOE_FLAG_C]),
    .result    (result),
    .carry_out (carry_out),
    .nib_out   (nib_out),
    .upd_c     (upd_c),
    .upd_dc    (upd_dc),
    .upd_z     (upd_z),
    .skip      (skip)
  );

  // A taken branch or skip flushes the prefetched word, which costs the second cycle.
  always @* begin
    pc_d = pc_q + 13'h0001;
    if (do_exec && is_jump) begin
      pc_d = {upper_latch_q[`BOE_LATCH_HI:`BOE_LATCH_LO], insn_q[10:0]};
    end else if (do_exec && (is_ret || is_ret_lit)) begin
      pc_d = stack_q[sp_pop];
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_q          <= `BOE_PC_RESET;
      pm_addr_q     <= `BOE_PC_RESET;
      insn_q        <= 14'h0000;
      valid_q       <= 1'b0;
      flush_q       <= 1'b0;
      acc_q         <= `BOE_ACC_RESET;
      status_q      <= 3'h0;
      gie_q         <= 1'b0;
      upper_latch_q <= 8'h00;
      sp_q          <= 3'h0;
    end else begin
      pc_q      <= pc_d;
      pm_addr_q <= pc_d;
      insn_q    <= pm_data;
      valid_q   <= 1'b1;
      flush_q   <= do_exec & (is_jump | is_ret | is_ret_lit | (is_reg_op & skip));
      if (latch_we) begin
        upper_latch_q <= latch_wdata;
      end
      if (stack_push) begin
        sp_q <= sp_q + 3'h1;
      end
      if (do_exec) begin
        if (upd_c) begin
          status_q[`BOE_FLAG_C] <= carry_out;
        end
        if (upd_dc) begin
          status_q[`BOE_FLAG_DC] <= nib_out;
        end
        if (upd_z) begin
          status_q[`BOE_FLAG_Z] <= (result == 8'h00);
        end
        if (is_reg_op) begin
          if (!insn_q[`BOE_DEST_BIT]) begin
            acc_q <= result;
          end
        end else if (is_load_lit || is_ret_lit) begin
          acc_q <= insn_q[7:0];
        end else if (is_lit_op) begin
          acc_q <= result;
        end
        if (is_ret || is_ret_lit) begin
          sp_q <= sp_pop;
        end
        if (is_ret_irq) begin
          gie_q <= 1'b1;
        end
      end
    end
  end

  // APB view: word 0 accumulator, 1 status, 2 program counter, 3 upper latch, 4 irq control.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr[11:2])
          10'h000: prdata <= {24'h000000, acc_q};
          10'h001: prdata <= {29'h00000000, status_q};
          10'h002: prdata <= {19'h00000, pc_q};
          10'h003: prdata <= {24'h000000, upper_latch_q};
          10'h004: prdata <= {24'h000000, gie_q, 7'h00};
          10'h005: prdata <= 32'h00000000;
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
  // The arrays carry no reset, so they live apart from the reset flops; a core write beats a bus write.
  always @(posedge clock) begin
    if (stack_push) begin
      stack_q[sp_q] <= stack_push_addr;
    end
    if (apb_go && pready && pwrite && paddr[11:2] == 10'h005) begin
      regs_q[pwdata[14:8]] <= pwdata[7:0];
    end
    if (do_exec && is_reg_op && insn_q[`BOE_DEST_BIT]) begin
      regs_q[insn_q[6:0]] <= result;
    end
  end
endmodule

// ---- boe_exec_unit_asserts.sv ----
// Concurrent checks on the execute unit ports.
`timescale 1ns/1ps
module boe_exec_unit_asserts (
  // Clock and reset
  input wire        clock,
  input wire        resetn,
  // Observed state
  input wire [12:0] pm_addr_q,
  input wire [13:0] pm_data,
  input wire [7:0]  acc_q,
  input wire [12:0] pc_q,
  input wire [2:0]  status_q,
  input wire        gie_q,
  input wire [7:0]  upper_latch_q,
  input wire        flush_q
);
  logic [13:0] x_q;
  logic        v_q;
  wire         e = v_q && !flush_q;
  wire  [8:0]  sum = acc_q + x_q[7:0];
  wire  [4:0]  nib = acc_q[3:0] + x_q[3:0];
  // The fetched word executes one edge later, so keep a copy of it.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      x_q <= 14'h0000;
      v_q <= 1'b0;
    end else begin
      x_q <= pm_data;
      v_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence jmp_s;
    e && x_q[13:11] == 3'h5;
  endsequence
  load_lit_a: assert property (e && x_q[13:10] == 4'hc |=> acc_q == $past(x_q[7:0]) && $stable(status_q))
    else $error("load literal wrong");
  add_lit_a: assert property (e && x_q[13:9] == 5'h1f |=> acc_q == $past(sum[7:0])
    && status_q[0] == $past(sum[8]) && status_q[1] == $past(nib[4]) && status_q[2] == (acc_q == 8'h00))
    else $error("add literal wrong");
  and_lit_a: assert property (e && x_q[13:8] == 6'h39 |=> acc_q == ($past(acc_q) & $past(x_q[7:0]))
    && status_q[2] == (acc_q == 8'h00) && status_q[1:0] == $past(status_q[1:0])) else $error("and literal wrong");
  or_lit_a: assert property (e && x_q[13:8] == 6'h38 |=> acc_q == ($past(acc_q) | $past(x_q[7:0]))
    && status_q[2] == (acc_q == 8'h00)) else $error("or literal wrong");
  jump_a: assert property (jmp_s |=> flush_q && pc_q == {$past(upper_latch_q[4:3]), $past(x_q[10:0])}
    && pm_addr_q == pc_q) else $error("jump target wrong");
  skip_a: assert property (e && x_q[13:8] == 6'h0b && !x_q[7] |=> flush_q == (acc_q == 8'h00) && $stable(status_q))
    else $error("decrement skip wrong");
  inc_a: assert property (e && x_q[13:8] == 6'h0a && !x_q[7] |=> status_q[2] == (acc_q == 8'h00)
    && status_q[1:0] == $past(status_q[1:0])) else $error("increment flags wrong");
  inc_skip_a: assert property (e && x_q[13:8] == 6'h0f && x_q[7] |=> $stable(status_q) && $stable(acc_q))
    else $error("increment skip wrong");
  ret_lit_a: assert property (e && x_q[13:10] == 4'hd |=> flush_q && acc_q == $past(x_q[7:0]) && $stable(status_q))
    else $error("literal return wrong");
  ret_a: assert property (e && x_q == 14'h0008 |=> flush_q && $stable(acc_q) && $stable(status_q))
    else $error("return wrong");
  ret_irq_a: assert property (e && x_q == 14'h0009 |=> gie_q && flush_q)
    else $error("irq return wrong");
endmodule

// ---- boe_prog_mem.sv ----
// Program memory model answering fetches from a word array.
`timescale 1ns/1ps
module boe_prog_mem (
  // Fetch
  input  wire [12:0] addr,
  output wire [13:0] data
);
  logic [13:0] mem [0:8191];
  // A combinational read keeps pace with one fetch every cycle.
  assign data = mem[addr];
endmodule

// ---- boe_exec_unit_tb.sv ----
// Self-checking bench for the execute unit.
`timescale 1ns/1ps
module boe_exec_unit_tb;
  logic clock = 0, resetn = 0, latch_we = 0, stack_push = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] latch_wdata = 0, acc_q, upper_latch_q, la = 0, lit;
  logic [12:0] stack_push_addr = 0, pm_addr_q, pc_q;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [13:0] pm_data;
  logic [2:0] status_q;
  logic gie_q, flush_q, pready, pslverr;
  logic [7:0] eq[$];
  logic [32:0] rq[$];
  logic [13:0] prog [0:9] = '{14'h30f8, 14'h3e18, 14'h3835, 14'h390f, 14'h0720, 14'h0a21, 14'h0d21, 14'h0b20,
    14'h30ee, 14'h2810};
  integer seed = 32'h0ef0, err_count = 0, total_checks = 0;
  always #20 clock = ~clock;
  boe_prog_mem i_pm (.addr(pm_addr_q), .data(pm_data));
  boe_exec_unit i_dut (.clock, .resetn, .pm_addr_q, .pm_data, .latch_we, .latch_wdata, .stack_push,
    .stack_push_addr, .acc_q, .status_q, .pc_q, .gie_q, .upper_latch_q, .flush_q, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  task chk(input string n, input logic [32:0] e, input logic [32:0] s);
    total_checks++;
    if (e !== s) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task conclude;
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // The master holds every request field until pready is seen at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) err_count++;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (resetn) begin
      if (acc_q !== la) chk("acc", eq.pop_front(), acc_q);
      la <= acc_q;
      if (psel && penable && pready && !pwrite) chk("apb", rq.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    for (int i = 0; i < 8192; i++) i_pm.mem[i] = 14'h0000;
    for (int i = 0; i < 10; i++) i_pm.mem[32 + i] = prog[i];
    lit = $random(seed) | 8'h81;
    i_pm.mem[13'h0810] = {6'h30, lit};
    i_pm.mem[13'h0811] = 14'h0009;
    i_pm.mem[13'h0812] = 14'h0520;
    i_pm.mem[13'h0813] = 14'h0fa1;
    i_pm.mem[13'h0814] = 14'h305a;
    i_pm.mem[13'h0815] = 14'h3030;
    i_pm.mem[13'h0816] = 14'h0421;
    i_pm.mem[13'h0817] = 14'h0420;
    i_pm.mem[13'h0818] = 14'h0008;
    i_pm.mem[13'h081a] = 14'h3477;
    i_pm.mem[13'h0820] = 14'h2820;
    eq = '{8'hf8, 8'h10, 8'h35, 8'h05, 8'h06, 8'h00, 8'hfe, 8'h00};
    eq.push_back(lit);
    eq.push_back(8'h01);
    eq.push_back(8'h30);
    eq.push_back(8'h31);
    eq.push_back(8'h77);
    repeat (4) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    latch_we <= 1;
    latch_wdata <= 8'h08;
    stack_push <= 1;
    stack_push_addr <= 13'h0820;
    @(posedge clock);
    latch_we <= 0;
    stack_push_addr <= 13'h081a;
    @(posedge clock);
    stack_push_addr <= 13'h0812;
    @(posedge clock);
    stack_push <= 0;
    apb(1, 12'h014, 32'h0000_2001);
    apb(1, 12'h014, 32'h0000_21ff);
    repeat (70) @(posedge clock);
    rq = '{{1'b0, 32'h1}, {1'b0, 32'h80}, {1'b0, 32'h08}, {1'b1, 32'h0}};
    apb(0, 12'h004, 0);
    apb(0, 12'h010, 0);
    apb(0, 12'h00c, 0);
    apb(0, 12'h040, 0);
    chk("acc left", 0, eq.size() + rq.size());
    conclude;
  end
  initial begin
    #20000;
    err_count++;
    conclude;
  end
endmodule
bind boe_exec_unit boe_exec_unit_asserts i_chk (.clock, .resetn, .pm_addr_q, .pm_data, .acc_q, .pc_q, .status_q, .gie_q,
  .upper_latch_q, .flush_q);
